// [design/bth_pkg.sv]
package bth_pkg;

   localparam int ATTEMPT_W    = 24;
   localparam int DEVSEL_CLKS  = 5;
   localparam int POST_MIN_DW  = 8;
   localparam int FIFO_DEPTH   = 8;
   localparam int DATA_W       = 32;
   localparam int DW_CNT_W     = 8;
   localparam int MTO_CLKS     = 1024;
   localparam logic [3:0] CMD_MEMWR = 4'h7;
   localparam logic [3:0] CMD_MWI   = 4'hF;
   localparam logic [2:0] DEVSEL_CNT_RST = 3'h0;

   typedef enum logic [1:0] {
      KIND_DW = 2'b00,
      KIND_PW = 2'b01,
      KIND_DR = 2'b10
   } bth_kind_t;

   typedef enum logic [2:0] {
      TERM_NORMAL = 3'b000,
      TERM_RETRY  = 3'b001,
      TERM_DISC   = 3'b010,
      TERM_TABORT = 3'b011,
      TERM_MABORT = 3'b100
   } bth_term_t;

   typedef enum logic [2:0] {
      RSP_NONE      = 3'b000,
      RSP_DATA      = 3'b001,
      RSP_DATA_DISC = 3'b010,
      RSP_RETRY     = 3'b011,
      RSP_TABORT    = 3'b100
   } bth_rsp_t;

   typedef struct packed {
      bth_kind_t   kind;
      logic [3:0]  cmd;
      logic [31:0] addr;
      logic        prefetch;
   } bth_xact_t;

   typedef struct packed {
      bth_term_t            term;
      logic [DW_CNT_W-1:0]  dwords;
   } bth_term_rpt_t;

   typedef struct packed {
      bth_kind_t kind;
      logic      multiPhase;
      logic      moreThanFetched;
      logic      locked;
      logic      atBoundary;
   } bth_treq_t;

   typedef struct packed {
      logic entering;
      logic notAtHead;
      logic pwPrecedes;
      logic queueFull;
      logic dupQueued;
      logic lockProp;
      logic discarding;
   } bth_qstate_t;

   typedef struct packed {
      logic dwExhaust;
      logic pwExhaust;
      logic drExhaust;
      logic pwTabort;
   } bth_serr_dis_t;

   typedef struct packed {
      logic rcvdTaTgt;
      logic sigTaInit;
      logic sigSerrPri;
      logic rcvdMaTgt;
   } bth_stat_t;

endpackage

// [design/bth_termination.sv]
`timescale 1ns/1ns

module bth_post_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rstn,
   input  wire logic                     inValid,
   output logic                          inReady,
   input  wire logic [W-1:0]             inData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [W-1:0]                  outData,
   output logic [$clog2(DEPTH+1)-1:0]    count
);
   localparam int AW = $clog2(DEPTH);
   initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   wire           doWr = inValid && inReady;
   wire           doRd = outValid && outReady;

   assign inReady  = count != DEPTH[$clog2(DEPTH+1)-1:0];
   assign outValid = count != '0;
   assign outData  = mem[rdPtr];

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         wrPtr <= wrPtr + AW'(doWr);
         rdPtr <= rdPtr + AW'(doRd);
         count <= count + $bits(count)'(doWr) - $bits(count)'(doRd);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (doWr)
         mem[wrPtr] <= inData;
   end
endmodule // bth_post_fifo

module bth_termination
   import bth_pkg::*;
#(
   parameter int ATTEMPTS_W = bth_pkg::ATTEMPT_W,
   parameter int MTO        = bth_pkg::MTO_CLKS
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rstn,
   input  wire logic                   xactLoad,
   input  wire bth_pkg::bth_xact_t     xactIn,
   input  wire logic                   frameStart,
   input  wire logic                   devselSeen,
   input  wire logic                   termValid,
   input  wire bth_pkg::bth_term_rpt_t termRpt,
   input  wire logic                   tgtReqValid,
   input  wire bth_pkg::bth_treq_t     tgtReq,
   input  wire bth_pkg::bth_qstate_t   qState,
   input  wire logic                   serrEnable,
   input  wire bth_pkg::bth_serr_dis_t serrDisable,
   input  wire bth_pkg::bth_stat_t     statClear,
   input  wire logic                   pwInValid,
   output logic                        pwInReady,
   input  wire logic [bth_pkg::DATA_W-1:0] pwInData,
   output logic                        pwOutValid,
   input  wire logic                   pwOutReady,
   output logic [bth_pkg::DATA_W-1:0]  pwOutData,
   output logic                        busy_r,
   output logic                        reissue_r,
   output bth_pkg::bth_xact_t          reissueXact_r,
   output bth_pkg::bth_rsp_t           tgtRsp_r,
   output bth_pkg::bth_stat_t          status_r,
   output logic                        serr_r,
   output logic                        dropQueued_r
);
   import bth_pkg::*;

   initial if (ATTEMPTS_W < 2 || MTO < 1) $error("Bad attempt width or master timeout");

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ATTEMPT = 2'b01,
      ST_WAIT   = 2'b10
   } bth_state_t;

   localparam int MTO_W = $clog2(MTO + 1);

   bth_state_t            state_r;
   bth_state_t            state_nxt;
   bth_xact_t             xact_r;
   logic [ATTEMPTS_W-1:0] attempts_r;
   logic [2:0]            devselCnt_r;
   logic                  devselWait_r;
   logic                  cmplValid_r;
   bth_kind_t             cmplKind_r;
   bth_term_t             cmplTerm_r;
   logic                  dwAbortPend_r;
   logic                  drAbortPend_r;
   logic [MTO_W-1:0]      mtoCnt_r;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifoCount;

   bth_post_fifo #(
      .W     (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) postFifo (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .inValid  (pwInValid),
      .inReady  (pwInReady),
      .inData   (pwInData),
      .outValid (pwOutValid),
      .outReady (pwOutReady),
      .outData  (pwOutData),
      .count    (fifoCount)
   );

   // Master side: a missing DEVSEL is folded into the target's termination report.
   wire        maTimeout  = devselWait_r && !devselSeen
                          && devselCnt_r == 3'(DEVSEL_CLKS - 1);
   wire        termEvt    = (state_r == ST_ATTEMPT) && (termValid || maTimeout);
   wire [2:0]  termCode   = maTimeout ? TERM_MABORT : termRpt.term;
   wire        isRetry    = termEvt && termCode == TERM_RETRY;
   wire        isDisc     = termEvt && termCode == TERM_DISC;
   wire        isTabort   = termEvt && termCode == TERM_TABORT;
   wire        isMabort   = termEvt && termCode == TERM_MABORT;
   wire        isPosted   = xact_r.kind == KIND_PW;
   wire        pwLeft     = isPosted && isDisc && pwOutValid;
   wire        reattempt  = isRetry || pwLeft;
   wire        exhausted  = reattempt && (&attempts_r);
   wire        doReissue  = reattempt && !exhausted;
   wire        finish     = termEvt && !doReissue;
   wire        serrDis    = xact_r.kind == KIND_DW ? serrDisable.dwExhaust
                          : xact_r.kind == KIND_DR ? serrDisable.drExhaust
                          : serrDisable.pwExhaust;
   wire        serrExh    = exhausted && serrEnable && !serrDis;
   wire        serrPwTa   = isTabort && isPosted && serrEnable && !serrDisable.pwTabort;
   wire [31:0] nextAddr   = xact_r.addr + {22'h000000, termRpt.dwords, 2'b00};
   wire [3:0]  nextCmd    = (isDisc && xact_r.cmd == CMD_MWI) ? CMD_MEMWR : xact_r.cmd;

   // Target side: decide the answer to an initiator's attempt.
   wire        sameKind   = cmplValid_r && cmplKind_r == tgtReq.kind;
   wire        abortPend  = tgtReq.kind == KIND_DW ? dwAbortPend_r
                          : tgtReq.kind == KIND_DR ? drAbortPend_r : 1'b0;
   wire        headBlock  = qState.notAtHead || (tgtReq.kind == KIND_DR && qState.pwPrecedes);
   wire        lockBlock  = qState.lockProp && !tgtReq.locked;
   wire        dlyRetry   = qState.entering || qState.queueFull || qState.dupQueued
                          || lockBlock || headBlock || !sameKind
                          || (tgtReq.kind == KIND_DR && qState.discarding);
   wire        pwRoom     = ($bits(fifoCount)+1)'(FIFO_DEPTH) - ($bits(fifoCount)+1)'(fifoCount)
                          >= ($bits(fifoCount)+1)'(POST_MIN_DW);
   wire        pwRetry    = !pwRoom || lockBlock;
   wire        pwDisc     = tgtReq.atBoundary || fifoCount == $bits(fifoCount)'(FIFO_DEPTH - 1);
   wire        readDisc   = !xact_r.prefetch || tgtReq.moreThanFetched;
   wire        cmplDisc   = tgtReq.kind == KIND_DW ? tgtReq.multiPhase
                          : (cmplTerm_r == TERM_NORMAL ? readDisc : tgtReq.moreThanFetched);
   wire        giveAbort  = abortPend || (!dlyRetry && cmplTerm_r == TERM_TABORT);
   wire        consume    = tgtReqValid && tgtReq.kind != KIND_PW && !abortPend && !dlyRetry;
   wire        mtoExpire  = cmplValid_r && mtoCnt_r == MTO_W'(MTO - 1);

   bth_rsp_t   rspNxt;
   always_comb
   begin
      rspNxt = RSP_NONE;
      if (tgtReqValid)
      begin
         if (tgtReq.kind == KIND_PW)
            rspNxt = pwRetry ? RSP_RETRY : (pwDisc ? RSP_DATA_DISC : RSP_DATA);
         else if (giveAbort)
            rspNxt = RSP_TABORT;
         else if (dlyRetry)
            rspNxt = RSP_RETRY;
         else
            rspNxt = cmplDisc || tgtReq.atBoundary ? RSP_DATA_DISC : RSP_DATA;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:    if (xactLoad) state_nxt = ST_WAIT;
         ST_WAIT:    if (frameStart) state_nxt = ST_ATTEMPT;
         ST_ATTEMPT: if (finish) state_nxt = ST_IDLE;
                     else if (doReissue) state_nxt = ST_WAIT;
         default:    state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r      <= ST_IDLE;
         devselWait_r <= 1'b0;
         devselCnt_r  <= DEVSEL_CNT_RST;
      end
      else
      begin
         state_r      <= state_nxt;
         devselWait_r <= frameStart || (devselWait_r && !devselSeen && !maTimeout);
         devselCnt_r  <= frameStart ? DEVSEL_CNT_RST : devselCnt_r + 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         xact_r        <= '0;
         attempts_r    <= '0;
         reissue_r     <= 1'b0;
         reissueXact_r <= '0;
      end
      else
      begin
         reissue_r <= doReissue;
         if (state_r == ST_IDLE && xactLoad)
         begin
            xact_r     <= xactIn;
            attempts_r <= '0;
         end
         else if (doReissue)
         begin
            attempts_r <= attempts_r + ATTEMPTS_W'(1);
            if (isDisc)
            begin
               xact_r.addr <= nextAddr;
               xact_r.cmd  <= nextCmd;
            end
         end
         if (doReissue)
            reissueXact_r <= isDisc
                           ? bth_xact_t'{xact_r.kind, nextCmd, nextAddr, xact_r.prefetch}
                           : xact_r;
      end
   end

   // Completions wait here for the initiator's repeat.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cmplValid_r   <= 1'b0;
         cmplKind_r    <= KIND_DW;
         cmplTerm_r    <= TERM_NORMAL;
         dwAbortPend_r <= 1'b0;
         drAbortPend_r <= 1'b0;
         mtoCnt_r      <= '0;
         dropQueued_r  <= 1'b0;
      end
      else
      begin
         dropQueued_r <= mtoExpire;
         if (finish && !isPosted && !exhausted)
         begin
            cmplValid_r <= 1'b1;
            cmplKind_r  <= xact_r.kind;
            cmplTerm_r  <= bth_term_t'(termCode);
         end
         else if (consume || mtoExpire)
            cmplValid_r <= 1'b0;
         if (!cmplValid_r || (tgtReqValid && tgtReq.kind == cmplKind_r))
            mtoCnt_r <= '0;
         else
            mtoCnt_r <= mtoCnt_r + MTO_W'(1);
         if (exhausted && xact_r.kind == KIND_DW)
            dwAbortPend_r <= 1'b1;
         else if (tgtReqValid && tgtReq.kind == KIND_DW)
            dwAbortPend_r <= 1'b0;
         if (exhausted && xact_r.kind == KIND_DR)
            drAbortPend_r <= 1'b1;
         else if (tgtReqValid && tgtReq.kind == KIND_DR)
            drAbortPend_r <= 1'b0;
      end
   end

   // Sticky status: a set in the clearing cycle wins.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         status_r <= '0;
         tgtRsp_r <= RSP_NONE;
         serr_r   <= 1'b0;
         busy_r   <= 1'b0;
      end
      else
      begin
         tgtRsp_r <= rspNxt;
         busy_r   <= state_nxt != ST_IDLE;
         serr_r   <= serrExh || serrPwTa;
         status_r.rcvdTaTgt  <= isTabort || (status_r.rcvdTaTgt && !statClear.rcvdTaTgt);
         status_r.sigTaInit  <= rspNxt == RSP_TABORT
                             || (status_r.sigTaInit && !statClear.sigTaInit);
         status_r.sigSerrPri <= serrExh || serrPwTa
                             || (status_r.sigSerrPri && !statClear.sigSerrPri);
         status_r.rcvdMaTgt  <= isMabort || (status_r.rcvdMaTgt && !statClear.rcvdMaTgt);
      end
   end

   chk_devsel_abort: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_ATTEMPT && frameStart == 1'b0 && devselWait_r && !devselSeen
       && devselCnt_r == 3'h4) |-> ##1 status_r.rcvdMaTgt)
      else $error("Missing DEVSEL did not give master abort");

   chk_retry_same_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
      (isRetry && isPosted && !(&attempts_r)) |=> reissue_r && reissueXact_r.addr == $past(xact_r.addr))
      else $error("Posted retry changed the address");

   chk_disc_advance: assert property (@(posedge clk_sys) disable iff (!rstn)
      (pwLeft && !(&attempts_r))
      |=> reissueXact_r.addr == $past(xact_r.addr) + {22'h000000, $past(termRpt.dwords), 2'b00})
      else $error("Disconnected posted write not advanced");

   chk_mwi_demote: assert property (@(posedge clk_sys) disable iff (!rstn)
      (pwLeft && xact_r.cmd == CMD_MWI && !(&attempts_r)) |=> reissueXact_r.cmd == CMD_MEMWR)
      else $error("Invalidate write not demoted");

   chk_exhaust_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
      exhausted |=> state_r == ST_IDLE && !reissue_r)
      else $error("Exhausted transaction reissued");

   chk_exhaust_tabort: assert property (@(posedge clk_sys) disable iff (!rstn)
      (drAbortPend_r && tgtReqValid && tgtReq.kind == KIND_DR) |=> tgtRsp_r == RSP_TABORT)
      else $error("Read after exhaustion not aborted");

   chk_exhaust_pend: assert property (@(posedge clk_sys) disable iff (!rstn)
      (exhausted && xact_r.kind != KIND_PW) |=> (dwAbortPend_r || drAbortPend_r))
      else $error("Exhausted delayed request not marked for abort");

   chk_posted_room: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tgtReqValid && tgtReq.kind == KIND_PW && fifoCount > 4'h0) |=> tgtRsp_r == RSP_RETRY)
      else $error("Posted write accepted without room");

   chk_ta_status: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tgtRsp_r == RSP_TABORT) |-> status_r.sigTaInit)
      else $error("Signaled abort not recorded");

   chk_serr_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
      serr_r |-> $past(serrEnable))
      else $error("System error raised while disabled");

endmodule // bth_termination

// [dv/bth_tgt_model.sv]
`timescale 1ns/1ns

module bth_tgt_model
(
   input  wire logic                   clk_sys,
   input  wire logic                   rstn,
   input  wire logic                   frameStart,
   input  wire logic                   noDevsel,
   input  wire bth_pkg::bth_term_rpt_t rptCfg,
   output logic                        devselSeen,
   output logic                        termValid,
   output bth_pkg::bth_term_rpt_t      termRpt
);
   import bth_pkg::*;

   // The target claims one clock after FRAME# and ends the attempt one clock later.
   // Outside an ending the report toggles so that a stale value is never mistaken for a fresh one.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         devselSeen <= 1'b0;
         termValid  <= 1'b0;
         termRpt    <= '0;
      end
      else
      begin
         devselSeen <= frameStart & ~noDevsel;
         termValid  <= devselSeen;
         termRpt    <= devselSeen ? rptCfg : ~termRpt;
      end
   end
endmodule // bth_tgt_model

// [dv/tb_top.sv]
`timescale 1ns/1ns

module tb_top;
   import bth_pkg::*;
   logic              clk_sys, rstn, xactLoad, frameStart, tgtReqValid, serrEnable;
   logic              pwInValid, pwOutReady, noDevsel, devselSeen, termValid;
   logic              pwInReady, pwOutValid, busy_r, reissue_r, serr_r, dropQueued_r;
   logic [DATA_W-1:0] pwInData, pwOutData;
   bth_xact_t         xactIn, reissueXact_r;
   bth_term_rpt_t     termRpt, rptCfg;
   bth_treq_t         tgtReq;
   bth_stat_t         statClear, status_r;
   bth_rsp_t          tgtRsp_r;
   bth_qstate_t       qState;
   bth_serr_dis_t     serrDisable;
   logic              bnd;
   int                errors, total_checks;

   bth_termination #(.ATTEMPTS_W(3), .MTO(16)) i_bth_termination (.clk_sys(clk_sys),
      .rstn(rstn), .xactLoad(xactLoad), .xactIn(xactIn), .frameStart(frameStart),
      .devselSeen(devselSeen), .termValid(termValid), .termRpt(termRpt),
      .tgtReqValid(tgtReqValid), .tgtReq(tgtReq), .qState(qState), .serrEnable(serrEnable),
      .serrDisable(serrDisable), .statClear(statClear), .pwInValid(pwInValid),
      .pwInReady(pwInReady),
      .pwInData(pwInData), .pwOutValid(pwOutValid), .pwOutReady(pwOutReady),
      .pwOutData(pwOutData), .busy_r(busy_r), .reissue_r(reissue_r),
      .reissueXact_r(reissueXact_r), .tgtRsp_r(tgtRsp_r), .status_r(status_r),
      .serr_r(serr_r), .dropQueued_r(dropQueued_r));

   bth_tgt_model i_bth_tgt_model (.clk_sys(clk_sys), .rstn(rstn), .frameStart(frameStart),
      .noDevsel(noDevsel), .rptCfg(rptCfg), .devselSeen(devselSeen),
      .termValid(termValid), .termRpt(termRpt));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // A few idle clocks first, because a load while busy is silently ignored.
   task automatic load(input bth_kind_t k, input logic [3:0] c, input logic [31:0] a,
                       input logic p);
      repeat (3) @(posedge clk_sys);
      xactLoad <= 1'b1;
      xactIn   <= '{k, c, a, p};
      @(posedge clk_sys);
      xactLoad <= 1'b0;
   endtask

   task automatic attempt(input bth_term_t t, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      rptCfg     <= '{t, d};
      frameStart <= 1'b1;
      @(posedge clk_sys);
      frameStart <= 1'b0;
      n = 0;
      while (termValid !== 1'b1)
      begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > 20)
         begin
            check("termValid wait", 0, 1);
            report_and_stop();
         end
      end
      @(posedge clk_sys);
      #1;
   endtask

   task automatic treq(input bth_kind_t k, input logic m, input logic f, input bth_rsp_t e);
      @(posedge clk_sys);
      tgtReqValid <= 1'b1;
      tgtReq      <= '{k, m, f, 1'b0, bnd};
      @(posedge clk_sys);
      tgtReqValid <= 1'b0;
      #1;
      check("tgtRsp_r", tgtRsp_r, e);
   endtask

   task automatic t_dw_retry();
      load(KIND_DW, CMD_MEMWR, 32'h00001000, 1'b0);
      treq(KIND_DW, 1'b1, 1'b0, RSP_RETRY);
      attempt(TERM_RETRY, 8'h00);
      check("reissue_r", reissue_r, 1);
      check("busy_r", busy_r, 1);
      check("reissue addr", reissueXact_r.addr, 32'h00001000);
      attempt(TERM_NORMAL, 8'h01);
      check("reissue_r", reissue_r, 0);
      qState <= '{lockProp: 1'b1, default: 1'b0};
      treq(KIND_DW, 1'b1, 1'b0, RSP_RETRY);
      qState <= '0;
      treq(KIND_DW, 1'b1, 1'b0, RSP_DATA_DISC);
   endtask

   task automatic t_abort();
      load(KIND_DW, CMD_MEMWR, 32'h00001100, 1'b0);
      attempt(TERM_TABORT, 8'h00);
      check("reissue_r", reissue_r, 0);
      check("rcvdTaTgt", status_r.rcvdTaTgt, 1);
      treq(KIND_DW, 1'b0, 1'b0, RSP_TABORT);
      check("sigTaInit", status_r.sigTaInit, 1);
      clear_status();
   endtask

   task automatic clear_status();
      @(posedge clk_sys);
      statClear <= '1;
      @(posedge clk_sys);
      statClear <= '0;
      #1;
      check("status_r", status_r, 0);
   endtask

   task automatic dr_case(input logic p, input bth_term_t t, input logic f, input bth_rsp_t e);
      load(KIND_DR, 4'h6, 32'h00002000, p);
      attempt(t, 8'h01);
      treq(KIND_DR, 1'b1, f, e);
   endtask

   task automatic t_dr_done();
      dr_case(1'b0, TERM_NORMAL, 1'b0, RSP_DATA_DISC);
      dr_case(1'b1, TERM_NORMAL, 1'b0, RSP_DATA);
      dr_case(1'b1, TERM_NORMAL, 1'b1, RSP_DATA_DISC);
      dr_case(1'b0, TERM_DISC, 1'b0, RSP_DATA);
      dr_case(1'b0, TERM_DISC, 1'b1, RSP_DATA_DISC);
      dr_case(1'b0, TERM_TABORT, 1'b0, RSP_TABORT);
      load(KIND_DR, 4'h6, 32'h00002000, 1'b0);
      attempt(TERM_NORMAL, 8'h01);
      qState <= '{discarding: 1'b1, default: 1'b0};
      treq(KIND_DR, 1'b1, 1'b0, RSP_RETRY);
      qState <= '0;
      treq(KIND_DR, 1'b1, 1'b0, RSP_DATA_DISC);
   endtask

   task automatic t_dr_exhaust();
      load(KIND_DR, 4'h6, 32'h00002400, 1'b0);
      repeat (7)
      begin
         attempt(TERM_RETRY, 8'h00);
         check("reissue_r", reissue_r, 1);
      end
      attempt(TERM_RETRY, 8'h00);
      check("serr_r", serr_r, 1);
      check("reissue_r", reissue_r, 0);
      treq(KIND_DR, 1'b0, 1'b0, RSP_TABORT);
   endtask

   task automatic t_posted();
      int n;
      int m;
      logic a;
      @(posedge clk_sys);
      pwInValid <= 1'b1;
      pwInData  <= 32'h00000000;
      n = 0;
      for (int i = 0; i < 12; i++)
      begin
         #1;
         a = pwInReady;
         @(posedge clk_sys);
         if (a)
         begin
            n++;
            pwInData <= n;
         end
      end
      pwInValid <= 1'b0;
      check("fifo fill", n, FIFO_DEPTH);
      treq(KIND_PW, 1'b0, 1'b0, RSP_RETRY);
      load(KIND_PW, CMD_MWI, 32'h00003000, 1'b0);
      attempt(TERM_DISC, 8'h02);
      check("reissue_r", reissue_r, 1);
      check("reissue addr", reissueXact_r.addr, 32'h00003008);
      check("reissue cmd", reissueXact_r.cmd, CMD_MEMWR);
      attempt(TERM_RETRY, 8'h00);
      check("reissue addr", reissueXact_r.addr, 32'h00003008);
      attempt(TERM_NORMAL, 8'h06);
      check("reissue_r", reissue_r, 0);
      // The drain side stalls every other clock to exercise the hold path.
      m = 0;
      for (int i = 0; i < 24; i++)
      begin
         @(posedge clk_sys);
         pwOutReady <= i[0];
         #1;
         if (pwOutValid === 1'b1 && pwOutReady === 1'b1)
         begin
            check("fifo data", pwOutData, m);
            m++;
         end
      end
      pwOutReady <= 1'b0;
      check("fifo drain", m, FIFO_DEPTH);
      check("pwOutValid", pwOutValid, 0);
      treq(KIND_PW, 1'b0, 1'b0, RSP_DATA);
      bnd <= 1'b1;
      treq(KIND_PW, 1'b0, 1'b0, RSP_DATA_DISC);
      bnd <= 1'b0;
   endtask

   task automatic t_drop();
      int seen;
      load(KIND_DW, CMD_MEMWR, 32'h00004000, 1'b0);
      attempt(TERM_NORMAL, 8'h01);
      seen = 0;
      for (int i = 1; i <= 40; i++)
      begin
         @(posedge clk_sys);
         #1;
         if (dropQueued_r === 1'b1 && seen == 0)
            seen = i;
      end
      // The held completion is dropped exactly one master timeout (16 clocks here) after it lands.
      check("dropQueued_r", seen, 16);
      treq(KIND_DW, 1'b0, 1'b0, RSP_RETRY);
   endtask

   task automatic t_devsel_miss();
      load(KIND_DR, 4'h6, 32'h00005000, 1'b0);
      @(posedge clk_sys);
      noDevsel   <= 1'b1;
      frameStart <= 1'b1;
      @(posedge clk_sys);
      frameStart <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      check("rcvdMaTgt early", status_r.rcvdMaTgt, 0);
      @(posedge clk_sys);
      #1;
      check("rcvdMaTgt", status_r.rcvdMaTgt, 1);
      noDevsel <= 1'b0;
   endtask

   task automatic t_errors();
      clear_status();
      load(KIND_PW, CMD_MEMWR, 32'h00006000, 1'b0);
      attempt(TERM_TABORT, 8'h00);
      check("serr_r", serr_r, 1);
      check("status_r", status_r, 4'hA);
      serrDisable <= '{dwExhaust: 1'b1, default: 1'b0};
      load(KIND_DW, CMD_MEMWR, 32'h00006100, 1'b0);
      repeat (8) attempt(TERM_RETRY, 8'h00);
      check("serr_r", serr_r, 0);
      check("reissue_r", reissue_r, 0);
      treq(KIND_DW, 1'b0, 1'b0, RSP_TABORT);
      serrDisable <= '0;
      load(KIND_PW, CMD_MEMWR, 32'h00006200, 1'b0);
      repeat (8) attempt(TERM_RETRY, 8'h00);
      check("serr_r", serr_r, 1);
      check("busy_r", busy_r, 0);
   endtask

   initial
   begin
      errors = 0;
      total_checks = 0;
      rstn = 1'b0;
      {xactLoad, frameStart, tgtReqValid, pwInValid, pwOutReady, noDevsel, bnd} = '0;
      qState = '0;
      serrDisable = '0;
      serrEnable = 1'b1;
      xactIn = '0;
      tgtReq = '0;
      rptCfg = '0;
      statClear = '0;
      pwInData = '0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      t_dw_retry();
      t_abort();
      t_dr_done();
      t_dr_exhaust();
      t_posted();
      t_drop();
      t_errors();
      t_devsel_miss();
      report_and_stop();
   end
endmodule // tb_top
